// >>> verilog/urs_pkg.sv
// constants shared by the serial receiver with sleep (address filter) mode.
// assumes a 16x oversampling tick from an external rate generator.
// Functional notes
// - With handshake selected, pull ready output low once receive is enabled.
// - A detected start bit begins bit timing and returns ready output high.
// - Each bit sample shifts the input level into the shift register, rightward.
// - After a full frame, copy to buffer and set completion and interrupt.
// - A read of the receive buffer clears the completion flag.
// - A frame finishing with completion still set flags overrun, buffer overwritten.
// - Interrupt request set at stop bit; cleared by acceptance or software.
// - Error flags are evaluated only when a frame moves into the buffer.
// - Low byte read or receive enable at zero clears all error flags.
// - Missing configured stop bits raise the framing error flag.
// - With parity on, a ones count against the chosen sense flags parity error.
// - Error sum is the OR of overrun, framing and parity errors.
// - Setting the sleep select bit puts the receiver into sleep mode.
// - In sleep, frames with data MSB zero are dropped with no flag changes.
// - In sleep, frames with data MSB one are received normally.
// - Frame: low start, data LSB first, optional parity, one or two high stops.
// - Parity sense zero selects odd, one selects even, only when parity enabled.
`default_nettype none

package urs_pkg;

  // ----------------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------------
  localparam int unsigned SHIFT_W   = 13;    // start + 9 data + parity + 2 stops
  localparam int unsigned DATA_W    = 9;
  localparam logic [3:0]  FRAME_MAX = 4'hD;  // longest frame in bits
  localparam logic [3:0]  LEN_7BIT  = 4'h7;
  localparam logic [3:0]  LEN_8BIT  = 4'h8;
  localparam logic [3:0]  LEN_9BIT  = 4'h9;

  // data length select codes
  localparam logic [2:0]  MODE_7BIT = 3'h4;
  localparam logic [2:0]  MODE_8BIT = 3'h5;
  localparam logic [2:0]  MODE_9BIT = 3'h6;

  // ----------------------------------------------------------------------
  // bit timing: 16 rate ticks per bit, first sample at mid start bit
  // ----------------------------------------------------------------------
  localparam logic [3:0]  TICK_LAST = 4'hF;
  localparam logic [3:0]  TICK_HALF = 4'h8;

  typedef enum logic [1:0] {URS_IDLE, URS_RECV, URS_XFER} urs_state_type;

  // data length in bits; unknown codes fall back to eight bits
  function automatic logic [3:0] urs_data_len(input logic [2:0] mode);
    case (mode)
      MODE_7BIT: urs_data_len = LEN_7BIT;
      MODE_9BIT: urs_data_len = LEN_9BIT;
      default:   urs_data_len = LEN_8BIT;
    endcase
  endfunction : urs_data_len

endpackage : urs_pkg

`default_nettype wire

// >>> verilog/urs_bit_timer.sv
// bit timer: turns the 16x rate tick into one sample pulse per bit.
// assumes rateTick is a one-cycle pulse synchronous to core_clk.
`default_nettype none

module urs_bit_timer
  import urs_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic restart,
  input  wire logic rateTick,
  output var  logic samplePulse
);

  logic [3:0] tickCnt_reg;
  logic [3:0] tickCnt_next;
  logic       wrap;

  // ----------------------------------------------------------------------
  // tick counter
  // ----------------------------------------------------------------------
  // restart loads half a bit so the first sample lands mid start bit
  assign wrap         = rateTick && (tickCnt_reg == TICK_LAST);
  assign tickCnt_next = restart ? TICK_HALF :
                        rateTick ? tickCnt_reg + 4'h1 : tickCnt_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tickCnt_reg <= TICK_HALF;
      samplePulse <= 1'b0;
    end else begin
      tickCnt_reg <= tickCnt_next;
      samplePulse <= wrap && !restart;
    end
  end

endmodule : urs_bit_timer

`default_nettype wire

// >>> verilog/urs_frame_check.sv
// frame check: aligns a shifted-in frame and extracts data, msb and errors.
// assumes the shift register was filled from the top, start bit first.
`default_nettype none

module urs_frame_check
  import urs_pkg::*;
(
  input  wire logic [SHIFT_W-1:0] frameBits,
  input  wire logic [3:0]         frameLen,
  input  wire logic [3:0]         dataLen,
  input  wire logic               parityEnable,
  input  wire logic               paritySense,
  input  wire logic               twoStopBits,
  output logic      [DATA_W-1:0]  dataOut,
  output logic                    dataMsb,
  output logic                    framingBad,
  output logic                    parityBad
);

  logic [SHIFT_W-1:0] aligned;
  logic [DATA_W-1:0]  dataMask;
  logic [3:0]         parIdx;
  logic [3:0]         stop1Idx;
  logic [3:0]         stop2Idx;
  logic [3:0]         msbIdx;
  logic               onesOdd;

  // ----------------------------------------------------------------------
  // alignment: a short frame sits at the top, so slide it down to bit 0
  // ----------------------------------------------------------------------
  assign aligned  = frameBits >> (FRAME_MAX - frameLen);
  assign dataMask = DATA_W'((10'h001 << dataLen) - 10'h001);
  assign dataOut  = aligned[DATA_W:1] & dataMask;
  assign msbIdx   = dataLen - 4'h1;
  assign dataMsb  = dataOut[msbIdx];
  assign parIdx   = dataLen + 4'h1;
  assign stop1Idx = dataLen + 4'h1 + {3'h0, parityEnable};
  assign stop2Idx = stop1Idx + 4'h1;

  // ----------------------------------------------------------------------
  // error terms
  // ----------------------------------------------------------------------
  // stop bits must be high; second one only checked when configured
  assign framingBad = !aligned[stop1Idx] || (twoStopBits && !aligned[stop2Idx]);
  // odd sense (0) fails on an even total, even sense (1) on an odd total
  assign onesOdd   = (^dataOut) ^ aligned[parIdx];
  assign parityBad = parityEnable && (onesOdd == paritySense);

endmodule : urs_frame_check

`default_nettype wire

// >>> verilog/urs_receiver.sv
// serial receiver top: start detection, bit shifting, buffer transfer,
// completion, interrupt request, error flags and sleep address filter.
// assumes all control levels and read strobes are synchronous to core_clk,
// and rateTick comes from an external rate generator at 16x the bit rate.
`default_nettype none

module urs_receiver
  import urs_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // serial side
  input  wire logic              serialIn,
  input  wire logic              rateTick,
  output var  logic              readyToRecv_n,
  // configuration levels
  input  wire logic [2:0]        modeSel,
  input  wire logic              twoStopBits,
  input  wire logic              paritySense,
  input  wire logic              parityEnable,
  input  wire logic              sleepEnable,
  input  wire logic              readySelect,
  input  wire logic              rxEnable,
  // cpu side strobes
  input  wire logic              bufReadLow,
  input  wire logic              bufReadHigh,
  input  wire logic              intAccept,
  input  wire logic              intClear,
  // status and data
  output var  logic [DATA_W-1:0] rxBuffer_reg,
  output var  logic              rxDone_reg,
  output var  logic              rxIntReq_reg,
  output var  logic              overrunErr_reg,
  output var  logic              framingErr_reg,
  output var  logic              parityErr_reg,
  output var  logic              errorSum_reg,
  output logic                   rxBusy
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  urs_state_type       state_reg;
  urs_state_type       state_next;
  logic [SHIFT_W-1:0]  shift_reg;
  logic [SHIFT_W-1:0]  shift_next;
  logic [3:0]          bitCnt_reg;
  logic [3:0]          bitCnt_next;
  logic [DATA_W-1:0]   rxBuffer_next;
  logic                rxDone_next;
  logic                rxIntReq_next;
  logic                overrunErr_next;
  logic                framingErr_next;
  logic                parityErr_next;
  logic                errorSum_next;
  logic                readyToRecv_next;

  logic [3:0]          dataLen;
  logic [3:0]          frameLen;
  logic                startSeen;
  logic                samplePulse;
  logic                falseStart;
  logic                lastBit;
  logic                frameEnd;
  logic                acceptFrame;
  logic                anyRead;
  logic                errClear;
  logic                overrunNow;
  logic [DATA_W-1:0]   frameData;
  logic                frameMsb;
  logic                framingBad;
  logic                parityBad;

  // ----------------------------------------------------------------------
  // frame length decode
  // ----------------------------------------------------------------------
  // start + data + optional parity + one or two stops
  assign dataLen  = urs_data_len(modeSel);
  assign frameLen = 4'h2 + dataLen + {3'h0, parityEnable} + {3'h0, twoStopBits};

  // ----------------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------------
  // the timer is restarted whenever a low line is seen while idle and enabled
  urs_bit_timer u_timer (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .restart     (startSeen),
    .rateTick    (rateTick),
    .samplePulse (samplePulse)
  );

  // ----------------------------------------------------------------------
  // frame checking
  // ----------------------------------------------------------------------
  urs_frame_check u_check (
    .frameBits    (shift_reg),
    .frameLen     (frameLen),
    .dataLen      (dataLen),
    .parityEnable (parityEnable),
    .paritySense  (paritySense),
    .twoStopBits  (twoStopBits),
    .dataOut      (frameData),
    .dataMsb      (frameMsb),
    .framingBad   (framingBad),
    .parityBad    (parityBad)
  );

  // ----------------------------------------------------------------------
  // sequencing conditions
  // ----------------------------------------------------------------------
  // a low line while idle and enabled is taken as a start bit
  assign startSeen  = (state_reg == URS_IDLE) && rxEnable && !serialIn;
  // a start bit that reads high at mid bit was only a glitch
  assign falseStart = (state_reg == URS_RECV) && samplePulse &&
                      (bitCnt_reg == 4'h0) && serialIn;
  assign lastBit    = (bitCnt_reg == frameLen - 4'h1);
  assign frameEnd   = (state_reg == URS_XFER);
  // sleep drops frames whose data msb is zero
  assign acceptFrame = frameEnd && (!sleepEnable || frameMsb);
  assign rxBusy     = (state_reg != URS_IDLE);

  // ----------------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      URS_IDLE: begin
        if (startSeen) begin
          state_next = URS_RECV;
        end
      end
      URS_RECV: begin
        if (falseStart) begin
          state_next = URS_IDLE;
        end else if (samplePulse && lastBit) begin
          state_next = URS_XFER;
        end
      end
      URS_XFER: begin
        state_next = URS_IDLE;
      end
      default: begin
        state_next = URS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // shift register and bit counter
  // ----------------------------------------------------------------------
  // each sample enters at the top and moves right, start bit through stop bit
  assign shift_next  = startSeen ? '0 :
                       (state_reg == URS_RECV && samplePulse) ?
                       {serialIn, shift_reg[SHIFT_W-1:1]} : shift_reg;
  assign bitCnt_next = startSeen ? 4'h0 :
                       (state_reg == URS_RECV && samplePulse) ?
                       bitCnt_reg + 4'h1 : bitCnt_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg  <= URS_IDLE;
      shift_reg  <= '0;
      bitCnt_reg <= 4'h0;
    end else begin
      state_reg  <= state_next;
      shift_reg  <= shift_next;
      bitCnt_reg <= bitCnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // buffer, completion and interrupt request
  // ----------------------------------------------------------------------
  // either byte read counts as a buffer read for the completion flag
  assign anyRead       = bufReadLow || bufReadHigh;
  assign rxBuffer_next = acceptFrame ? frameData : rxBuffer_reg;
  // a new frame wins over a read in the same cycle
  assign rxDone_next   = acceptFrame || (rxDone_reg && !anyRead);
  // interrupt raised with the stop bit; acceptance or software clears it
  assign rxIntReq_next = acceptFrame ||
                         (rxIntReq_reg && !intAccept && !intClear);

  // ----------------------------------------------------------------------
  // error flags
  // ----------------------------------------------------------------------
  // errors are only judged on transfer; a clear in that cycle loses
  assign errClear        = bufReadLow || !rxEnable;
  // a read in the same cycle already took the old word, so no overrun
  assign overrunNow      = rxDone_reg && !anyRead;
  assign overrunErr_next = acceptFrame ? overrunNow :
                           errClear ? 1'b0 : overrunErr_reg;
  assign framingErr_next = acceptFrame ? framingBad :
                           errClear ? 1'b0 : framingErr_reg;
  assign parityErr_next  = acceptFrame ? parityBad :
                           errClear ? 1'b0 : parityErr_reg;
  assign errorSum_next   = overrunErr_next || framingErr_next ||
                           parityErr_next;

  // ----------------------------------------------------------------------
  // ready-to-receive handshake
  // ----------------------------------------------------------------------
  // low only while enabled and waiting for a frame; the pin stays high
  // when the handshake function is not selected
  assign readyToRecv_next = !(readySelect && rxEnable &&
                              (state_next == URS_IDLE));

  // ----------------------------------------------------------------------
  // status registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxBuffer_reg   <= '0;
      rxDone_reg     <= 1'b0;
      rxIntReq_reg   <= 1'b0;
      overrunErr_reg <= 1'b0;
      framingErr_reg <= 1'b0;
      parityErr_reg  <= 1'b0;
      errorSum_reg   <= 1'b0;
      readyToRecv_n  <= 1'b1;
    end else begin
      rxBuffer_reg   <= rxBuffer_next;
      rxDone_reg     <= rxDone_next;
      rxIntReq_reg   <= rxIntReq_next;
      overrunErr_reg <= overrunErr_next;
      framingErr_reg <= framingErr_next;
      parityErr_reg  <= parityErr_next;
      errorSum_reg   <= errorSum_next;
      readyToRecv_n  <= readyToRecv_next;
    end
  end

endmodule : urs_receiver

`default_nettype wire

// >>> tb/urs_receiver_sva.sv
// concurrent checks on the serial receiver top ports.
// assumes one clock domain and the synchronous active high reset.
`default_nettype none

module urs_receiver_sva
  import urs_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              serialIn,
  input wire logic              rateTick,
  input wire logic              readyToRecv_n,
  input wire logic [2:0]        modeSel,
  input wire logic              twoStopBits,
  input wire logic              paritySense,
  input wire logic              parityEnable,
  input wire logic              sleepEnable,
  input wire logic              readySelect,
  input wire logic              rxEnable,
  input wire logic              bufReadLow,
  input wire logic              bufReadHigh,
  input wire logic              intAccept,
  input wire logic              intClear,
  input wire logic [DATA_W-1:0] rxBuffer_reg,
  input wire logic              rxDone_reg,
  input wire logic              rxIntReq_reg,
  input wire logic              overrunErr_reg,
  input wire logic              framingErr_reg,
  input wire logic              parityErr_reg,
  input wire logic              errorSum_reg,
  input wire logic              rxBusy
);
  // ----------------------------------------------------
  // assertions
  // ----------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // enabled idle receiver with a low line is a start; clears only hold while idle
  sequence sStart;
    rxEnable && !rxBusy && !serialIn;
  endsequence
  sequence sIdleClear;
    (bufReadLow || !rxEnable) && !rxBusy;
  endsequence

  AST_READY_LOW: assert property (readySelect && rxEnable ##1 !rxBusy |-> !readyToRecv_n)
    else $error("ready output not low while enabled");
  AST_READY_HIGH: assert property (!(readySelect && rxEnable) |=> readyToRecv_n)
    else $error("ready output low while not enabled");
  AST_START_BUSY: assert property (sStart |=> rxBusy && readyToRecv_n)
    else $error("start bit not taken");
  AST_BUF_WITH_DONE: assert property ($changed(rxBuffer_reg) |-> rxDone_reg && rxIntReq_reg && $past(rxBusy))
    else $error("buffer changed without completion");
  AST_READ_CLEARS: assert property ((bufReadLow || bufReadHigh) && !rxBusy |=> !rxDone_reg)
    else $error("read did not clear completion");
  AST_ERR_CLEAR: assert property (sIdleClear |=> !(overrunErr_reg || framingErr_reg || parityErr_reg || errorSum_reg))
    else $error("error flags not cleared");
  AST_OVR_CAUSE: assert property ($rose(overrunErr_reg) |-> $past(rxDone_reg) && $past(rxBusy))
    else $error("overrun without pending data");
  AST_ERR_AT_XFER: assert property (!$past(rxBusy) |-> !$rose(framingErr_reg) && !$rose(parityErr_reg))
    else $error("error flag set outside transfer");
  AST_SUM_OR: assert property (errorSum_reg == (overrunErr_reg || framingErr_reg || parityErr_reg))
    else $error("error sum is not the or of the flags");
  AST_INT_CLEAR: assert property ((intAccept || intClear) && !rxBusy |=> !rxIntReq_reg)
    else $error("interrupt request not cleared");
endmodule : urs_receiver_sva

bind urs_receiver urs_receiver_sva u_sva (
  .core_clk(core_clk), .sys_rst(sys_rst), .serialIn(serialIn), .rateTick(rateTick),
  .readyToRecv_n(readyToRecv_n), .modeSel(modeSel), .twoStopBits(twoStopBits),
  .paritySense(paritySense), .parityEnable(parityEnable), .sleepEnable(sleepEnable),
  .readySelect(readySelect), .rxEnable(rxEnable), .bufReadLow(bufReadLow),
  .bufReadHigh(bufReadHigh), .intAccept(intAccept), .intClear(intClear),
  .rxBuffer_reg(rxBuffer_reg), .rxDone_reg(rxDone_reg), .rxIntReq_reg(rxIntReq_reg),
  .overrunErr_reg(overrunErr_reg), .framingErr_reg(framingErr_reg),
  .parityErr_reg(parityErr_reg), .errorSum_reg(errorSum_reg), .rxBusy(rxBusy)
);

`default_nettype wire

// >>> tb/urs_remote_tx.sv
// remote transmitter model driving the receiver serial input.
// assumes rateTick runs at 16x the bit rate; line idles high.
`default_nettype none

module urs_remote_tx
  import urs_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rateTick,
  output var  logic serialOut
);
  timeunit 1ns;
  timeprecision 1ps;

  initial serialOut = 1'b1;

  // hold one level for a whole bit of 16 rate ticks
  task automatic put_bit(input logic b);
    int n;
    n = 0;
    serialOut <= b;
    while (n < 16) begin
      @(posedge core_clk);
      if (rateTick) n++;
    end
  endtask : put_bit

  // badP flips parity, badS drops the last stop bit low on purpose
  task automatic send(input logic [8:0] d, input int len, input logic par, input logic even,
                      input logic two, input logic badP, input logic badS);
    int i;
    put_bit(1'b0);
    for (i = 0; i < len; i++) put_bit(d[i]);
    if (par) put_bit((^d) ^ ~even ^ badP);
    if (two) put_bit(1'b1);
    put_bit(~badS);
    put_bit(1'b1);
    put_bit(1'b1);
  endtask : send
endmodule : urs_remote_tx

`default_nettype wire

// >>> tb/urs_receiver_tb.sv
// self-checking bench: a remote transmitter sends random frames and a
// reference model predicts every result; assumes the bound checker.
`default_nettype none

module urs_receiver_tb
  import urs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              core_clk, sys_rst, serialIn, readyToRecv_n, rxBusy;
  logic              rateTick = 1'b0;
  logic [2:0]        modeSel;
  logic              twoStopBits, paritySense, parityEnable, sleepEnable, readySelect, rxEnable;
  logic              bufReadLow, bufReadHigh, intAccept, intClear;
  logic [DATA_W-1:0] rxBuffer_reg, eBuf;
  logic              rxDone_reg, rxIntReq_reg, overrunErr_reg, framingErr_reg;
  logic              parityErr_reg, errorSum_reg, eDone, eInt, eOvr, eFe, ePe;
  logic [1:0]        tickCnt = 2'h0;
  logic [15:0]       seed;
  int                badCount, checks;

  urs_receiver uut (.core_clk(core_clk), .sys_rst(sys_rst), .serialIn(serialIn),
    .rateTick(rateTick), .readyToRecv_n(readyToRecv_n), .modeSel(modeSel),
    .twoStopBits(twoStopBits), .paritySense(paritySense), .parityEnable(parityEnable),
    .sleepEnable(sleepEnable), .readySelect(readySelect), .rxEnable(rxEnable),
    .bufReadLow(bufReadLow), .bufReadHigh(bufReadHigh), .intAccept(intAccept),
    .intClear(intClear), .rxBuffer_reg(rxBuffer_reg), .rxDone_reg(rxDone_reg),
    .rxIntReq_reg(rxIntReq_reg), .overrunErr_reg(overrunErr_reg),
    .framingErr_reg(framingErr_reg), .parityErr_reg(parityErr_reg),
    .errorSum_reg(errorSum_reg), .rxBusy(rxBusy));
  urs_remote_tx tx (.core_clk(core_clk), .rateTick(rateTick), .serialOut(serialIn));

  // 250 MHz clock; rate tick every 4 cycles keeps frames short
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    tickCnt <= tickCnt + 2'h1;
    rateTick <= (tickCnt == 2'h3);
  end

  // ----------------------------------------------------
  // reference model and checks
  // ----------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic compare_all;
    cmp(rxBuffer_reg, eBuf);
    cmp(9'({rxDone_reg, rxIntReq_reg}), 9'({eDone, eInt}));
    cmp(9'({overrunErr_reg, framingErr_reg, parityErr_reg}), 9'({eOvr, eFe, ePe}));
    cmp(9'(errorSum_reg), 9'(eOvr | eFe | ePe));
    cmp(9'(readyToRecv_n), 9'(!(readySelect && rxEnable)));
    cmp(9'(rxBusy), 9'h000);
  endtask : compare_all

  // k: 0 low byte read, 1 high read, 2 accept, 3 software clear, 4 none
  task automatic strobe(input int k);
    @(posedge core_clk);
    {bufReadLow, bufReadHigh, intAccept, intClear} <= {k == 0, k == 1, k == 2, k == 3};
    @(posedge core_clk);
    {bufReadLow, bufReadHigh, intAccept, intClear} <= 4'h0;
    #1;
    if (k < 2) eDone = 1'b0;
    if (k == 0) {eOvr, eFe, ePe} = 3'h0;
    if (k == 2 || k == 3) eInt = 1'b0;
    compare_all();
  endtask : strobe

  // c: parity on, even, two stops, bad parity, bad stop; fm[1] forces msb to fm[0]
  task automatic frame(input logic [8:0] d, input logic [2:0] m, input logic [4:0] c,
                       input logic [1:0] fm);
    int   len;
    logic msb;
    len = (m == MODE_7BIT) ? 7 : (m == MODE_9BIT) ? 9 : 8;
    d = d & 9'((1 << len) - 1);
    if (fm[1]) d[len-1] = fm[0];
    msb = d[len-1];
    @(posedge core_clk);
    {modeSel, parityEnable, paritySense, twoStopBits} <= {m, c[0], c[1], c[2]};
    tx.send(d, len, c[0], c[1], c[2], c[3], c[4]);
    #1;
    if (!rxEnable) {eOvr, eFe, ePe} = 3'h0;
    else if (!sleepEnable || msb) begin
      {eOvr, eDone, eInt, eBuf, eFe, ePe} = {eDone, 1'b1, 1'b1, d, c[4], c[0] & c[3]};
    end
    compare_all();
  endtask : frame

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // main sequence: random frames over all modes, then sleep, then disable
  initial begin
    int i;
    {sys_rst, modeSel} = {1'b1, MODE_8BIT};
    {twoStopBits, paritySense, parityEnable, sleepEnable, readySelect, rxEnable} = 6'h0;
    {bufReadLow, bufReadHigh, intAccept, intClear} = 4'h0;
    {seed, badCount, checks, eBuf} = {16'h29D3, 32'h0, 32'h0, 9'h000};
    {eDone, eInt, eOvr, eFe, ePe} = 5'h00;
    repeat (8) @(posedge core_clk);
    {sys_rst, rxEnable, readySelect} <= 3'h3;
    for (i = 0; i < 36; i++) begin
      seed = lfsr_next(seed);
      strobe(seed[15:13] % 5);
      @(posedge core_clk);
      readySelect <= seed[4];
      sleepEnable <= (i >= 24);
      frame(seed[8:0], 3'(4 + i % 4), seed[13:9], {i >= 24, ~i[0]});
    end
    @(posedge core_clk);
    sleepEnable <= 1'b0;
    frame(9'h0A5, MODE_8BIT, 5'h14, 2'h0);
    @(posedge core_clk);
    rxEnable <= 1'b0;
    frame(9'h03C, MODE_8BIT, 5'h00, 2'h0);
    finish_test();
  end

  // watchdog well past the longest expected run
  initial begin
    repeat (60000) @(posedge core_clk);
    badCount++;
    finish_test();
  end
endmodule : urs_receiver_tb

`default_nettype wire
